// *** rtl/nce_exec_core.sv ***
// Notes on behaviour
// (RULE1) machine cycle equals one selected cpu clock
// (RULE2) skipping table-indirect execute costs one cycle
// (RULE3) skipping three-byte branch/call costs two cycles
// (RULE4) load A from HL, L++, skip on wrap
// (RULE5) swap A with HL, L--, skip on F
// (RULE6) table read from PC page plus DE
// (RULE7) software clears B before full table read
// (RULE8) peripheral bit address from operand and L
// (RULE9) H-relative bit address in selected bank
// (RULE10) add with carry, carry out, no skip
// (RULE11) subtract with borrow into carry, no skip
// (RULE12) rotate A right through carry
// (RULE13) carry AND/OR/XOR with memory bit
// (RULE14) test bit, skip if set, clear it
// (RULE15) branch to PC page plus DE
// (RULE16) relative branch reach -15..-1, +2..+16
// (RULE17) direct address bank from enable and select
// (RULE18) DE/DL bank 0, fixed/peripheral bank 15
// (RULE19) fixed bit space FB0-FBF and FF0-FFF
// (RULE20) table-indirect address even, 20H to 7FH
// (RULE21) eight-bit direct address must be even
// (RULE22) only first of string load group acts
// (RULE23) skipped instruction changes nothing but PC; here the skip also clears the load group
module nce_exec_core
   import nce_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // status
   output logic busy
);
   import nce_pkg::*;

   logic [3:0] dmem [0:4095];
   logic [7:0] pmem [0:4095];
   logic [31:0] rf_reg, rf_next;
   logic [11:0] pc_reg, pc_next;
   logic cy_reg, cy_next;
   logic [1:0] clk_sel_reg;
   logic bank_en_reg;
   logic [3:0] bank_sel_reg;
   nce_state_e state_reg;
   nce_grp_e grp_reg, grp_next;
   logic [2:0] mc_left_reg, last_mc_reg;
   logic [3:0] div_cnt_reg;
   logic skip_pend_reg, op_err_reg;
   logic [11:0] skip_len_reg, dm_addr_reg, pm_addr_reg;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic skip, op_err, mwe;
   logic [3:0] mwdata;

   // apb decode
   wire acc = psel & penable;
   wire commit = ce & acc & pready_reg;
   wire wr_ok = commit & pwrite & ~pslverr_reg;
   wire hit_ctrl = paddr == NCE_OFS_CTRL;
   wire hit_cmd = paddr == NCE_OFS_CMD;
   wire hit_regs = paddr == NCE_OFS_REGS;
   wire hit_stat = paddr == NCE_OFS_STAT;
   wire hit_pcw = paddr == NCE_OFS_PCW;
   wire hit_dmem = paddr == NCE_OFS_DMEM;
   wire hit_pmem = paddr == NCE_OFS_PMEM;
   wire mapped = hit_ctrl | hit_cmd | hit_regs | hit_stat | hit_pcw
      | hit_dmem | hit_pmem;
   // a command is refused while the previous one still runs
   wire refuse = ~mapped | (pwrite & hit_cmd & state_reg == NCE_ST_RUN);
   wire go = wr_ok & hit_cmd;
   wire exe = go & ~skip_pend_reg;

   // command fields
   wire [4:0] cmd_op = pwdata[NCE_CMD_OP_LSB +: 5];
   wire [1:0] cmd_nxt = pwdata[NCE_CMD_NXT_LSB +: 2];
   wire [7:0] opnd = pwdata[NCE_CMD_OPND_LSB +: 8];

   wire [3:0] a = rf_reg[NCE_A_LSB +: 4];
   wire [3:0] l = rf_reg[NCE_L_LSB +: 4];
   wire [3:0] h = rf_reg[NCE_H_LSB +: 4];
   wire [3:0] e = rf_reg[NCE_E_LSB +: 4];
   wire [3:0] d = rf_reg[NCE_D_LSB +: 4];
   wire [3:0] l_inc = l + 4'h1;
   wire [3:0] l_dec = l - 4'h1;

   // bank selection per addressing form
   wire [3:0] mb_hl = bank_en_reg ? bank_sel_reg : NCE_BANK0;
   // (RULE17) direct form splits 00-7F / F80-FFF without enable
   wire [3:0] mb_dir = bank_en_reg ? bank_sel_reg
      : (opnd[7] ? NCE_BANK15 : NCE_BANK0);
   wire [11:0] hl_addr = {mb_hl, h, l};
   wire [11:0] dir_addr = {mb_dir, opnd};
   // (RULE18) DE-indirect always bank 0
   wire [11:0] de_addr = {NCE_BANK0, d, e};

   // bit addressing: operand top bits pick the form
   wire is_fmem = opnd[7];
   wire is_pmem = opnd[7:4] == NCE_PMEM_TAG;
   wire is_hrel = opnd[7:6] == 2'b00;
   // (RULE19) fixed form reaches only the FB and FF pages
   wire [3:0] fpage = opnd[6] ? NCE_FMEM_HI_PAGE : NCE_FMEM_LO_PAGE;
   // (RULE8) peripheral form: operand bits with L[3:2], bit L[1:0]
   wire [11:0] p_addr = {NCE_BANK15, NCE_PMEM_PAGE, opnd[3:0], l[3:2]};
   // (RULE9) H-relative form inside the selected bank
   wire [11:0] h_addr = {mb_hl, h, opnd[3:0]};
   wire [11:0] bit_addr = is_fmem ? {NCE_BANK15, fpage, opnd[3:0]}
      : (is_pmem ? p_addr : h_addr);
   wire [1:0] bsel = is_pmem ? l[1:0] : opnd[5:4];
   wire bad_bit = ~(is_fmem | is_pmem | is_hrel);
   wire is_bitop = cmd_op inside {NCE_OP_BIT_LD, NCE_OP_BIT_ST,
      NCE_OP_CY_AND, NCE_OP_CY_OR, NCE_OP_CY_XOR, NCE_OP_TSC};

   wire [11:0] rd_addr = is_bitop ? bit_addr
      : (cmd_op == NCE_OP_LD_AMEM) ? dir_addr
      : (cmd_op == NCE_OP_LD_ADE) ? de_addr : hl_addr;
   wire [3:0] mrd = dmem[rd_addr];
   wire mbit = mrd[bsel];
   // (RULE6) page-relative table address
   wire [7:0] tbl = pmem[{pc_reg[11:8], d, e}];

   wire [4:0] sum5 = {1'b0, a} + {1'b0, mrd} + {4'h0, cy_reg};
   wire [4:0] dif5 = {1'b0, a} - {1'b0, mrd} - {4'h0, cy_reg};
   wire signed [7:0] rel = opnd;
   wire rel_ok = (rel >= NCE_REL_BK_MIN && rel <= NCE_REL_BK_MAX)
      || (rel >= NCE_REL_FW_MIN && rel <= NCE_REL_FW_MAX);

   // (RULE2) (RULE3) skip cost from the kind of the next instruction
   wire [2:0] scost = (cmd_nxt == NCE_NXT_ABS3) ? NCE_SKIP_LONG
      : NCE_SKIP_SHORT;
   wire [2:0] base = nce_base(cmd_op);
   wire [2:0] mc_tot = base + (skip ? scost : 3'd0);
   wire [3:0] div_ld = nce_div(clk_sel_reg);
   wire tick = div_cnt_reg == 4'd0;

   always_comb
   begin
      rf_next = rf_reg;
      cy_next = cy_reg;
      pc_next = pc_reg;
      skip = 1'b0;
      op_err = 1'b0;
      mwe = 1'b0;
      mwdata = mrd;
      grp_next = NCE_GRP_NONE;
      case (cmd_op)
         NCE_OP_LD_HLINC:
         begin
            // (RULE4) read then bump L only
            rf_next[NCE_A_LSB +: 4] = mrd;
            rf_next[NCE_L_LSB +: 4] = l_inc;
            skip = l_inc == 4'h0;
         end
         NCE_OP_XCH_HLDEC:
         begin
            // (RULE5) swap then drop L only
            rf_next[NCE_A_LSB +: 4] = mrd;
            rf_next[NCE_L_LSB +: 4] = l_dec;
            mwe = 1'b1;
            mwdata = a;
            skip = l_dec == 4'hf;
         end
         NCE_OP_TBL_PCDE:
            rf_next[NCE_A_LSB +: 8] = tbl;
         NCE_OP_BIT_LD:
         begin
            op_err = bad_bit;
            cy_next = bad_bit ? cy_reg : mbit;
         end
         NCE_OP_BIT_ST:
         begin
            op_err = bad_bit;
            mwe = ~bad_bit;
            mwdata[bsel] = cy_reg;
         end
         // (RULE10) carry in and carry out
         NCE_OP_ADD_WITH_CARRY:
            {cy_next, rf_next[NCE_A_LSB +: 4]} = sum5;
         // (RULE11) borrow lands in carry
         NCE_OP_SUB_WITH_BORROW:
            {cy_next, rf_next[NCE_A_LSB +: 4]} = dif5;
         NCE_OP_ROTATE_RIGHT_CARRY:
         begin
            // (RULE12) carry into bit 3, bit 0 into carry
            rf_next[NCE_A_LSB +: 4] = {cy_reg, a[3:1]};
            cy_next = a[0];
         end
         // (RULE13) boolean carry ops
         NCE_OP_CY_AND:
         begin
            op_err = bad_bit;
            cy_next = bad_bit ? cy_reg : cy_reg & mbit;
         end
         NCE_OP_CY_OR:
         begin
            op_err = bad_bit;
            cy_next = bad_bit ? cy_reg : cy_reg | mbit;
         end
         NCE_OP_CY_XOR:
         begin
            op_err = bad_bit;
            cy_next = bad_bit ? cy_reg : cy_reg ^ mbit;
         end
         NCE_OP_TSC:
         begin
            // (RULE14) skip on one, bit cleared either way
            op_err = bad_bit;
            skip = ~bad_bit & mbit;
            mwe = ~bad_bit;
            mwdata[bsel] = 1'b0;
         end
         // (RULE15) keep PC page, DE is the low byte
         NCE_OP_BR_PCDE:
            pc_next = {pc_reg[11:8], d, e};
         NCE_OP_BR_REL:
         begin
            // (RULE16) out-of-reach distance leaves PC alone
            op_err = ~rel_ok;
            if (rel_ok)
               pc_next = pc_reg + {{4{opnd[7]}}, opnd};
         end
         NCE_OP_LD_AIMM:
         begin
            // (RULE22) a repeated load of the same group is a no-op
            grp_next = NCE_GRP_A;
            if (grp_reg != NCE_GRP_A)
               rf_next[NCE_A_LSB +: 4] = opnd[3:0];
         end
         NCE_OP_LD_HLIMM:
         begin
            grp_next = NCE_GRP_HL;
            if (grp_reg != NCE_GRP_HL)
               rf_next[NCE_L_LSB +: 8] = opnd;
         end
         NCE_OP_LD_AMEM, NCE_OP_LD_ADE:
            rf_next[NCE_A_LSB +: 4] = mrd;
         default:
            rf_next = rf_reg;
      endcase
   end

   // apb answer: one wait state, data and error flopped
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready_reg <= acc & ~pready_reg;
         pslverr_reg <= acc & ~pready_reg & refuse;
         if (acc & ~pready_reg & ~pwrite)
            prdata_reg <= hit_ctrl ? {24'h0, bank_sel_reg, 1'b0,
                  bank_en_reg, clk_sel_reg}
               : hit_regs ? rf_reg
               : hit_stat ? {4'h0, pc_reg, 9'h0, last_mc_reg,
                  op_err_reg, skip_pend_reg, cy_reg, busy}
               : hit_pcw ? {15'h0, cy_reg, 4'h0, pc_reg}
               : hit_dmem ? {12'h0, dmem[dm_addr_reg], 4'h0, dm_addr_reg}
               : hit_pmem ? {8'h0, pmem[pm_addr_reg], 4'h0, pm_addr_reg}
               : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         clk_sel_reg <= NCE_CTRL_RST[NCE_CTRL_CLK_LSB +: 2];
         bank_en_reg <= NCE_CTRL_RST[NCE_CTRL_BE_BIT];
         bank_sel_reg <= NCE_CTRL_RST[NCE_CTRL_BS_LSB +: 4];
         dm_addr_reg <= 12'h000;
         pm_addr_reg <= 12'h000;
      end
      else if (wr_ok)
      begin
         if (hit_ctrl)
         begin
            clk_sel_reg <= pwdata[NCE_CTRL_CLK_LSB +: 2];
            bank_en_reg <= pwdata[NCE_CTRL_BE_BIT];
            bank_sel_reg <= pwdata[NCE_CTRL_BS_LSB +: 4];
         end
         if (hit_dmem)
            dm_addr_reg <= pwdata[11:0];
         if (hit_pmem)
            pm_addr_reg <= pwdata[11:0];
      end
   end

   // the executing command owns the write port over software
   always_ff @(posedge clk)
   begin
      if (ce & exe & mwe)
         dmem[rd_addr] <= mwdata;
      else if (wr_ok & hit_dmem & pwdata[NCE_MEM_WR_BIT])
         dmem[pwdata[11:0]] <= pwdata[NCE_MEM_DATA_LSB +: 4];
   end

   always_ff @(posedge clk)
   begin
      if (wr_ok & hit_pmem & pwdata[NCE_MEM_WR_BIT])
         pmem[pwdata[11:0]] <= pwdata[NCE_MEM_DATA_LSB +: 8];
   end

   // architectural state
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rf_reg <= 32'h0000_0000;
         pc_reg <= 12'h000;
         cy_reg <= 1'b0;
         grp_reg <= NCE_GRP_NONE;
         skip_pend_reg <= 1'b0;
         skip_len_reg <= NCE_LEN_ONE;
         op_err_reg <= 1'b0;
         last_mc_reg <= 3'd0;
      end
      else if (go & skip_pend_reg)
      begin
         // (RULE23) the skipped command moves PC past itself and ends any load group
         pc_reg <= pc_reg + skip_len_reg;
         skip_pend_reg <= 1'b0;
         grp_reg <= NCE_GRP_NONE;
      end
      else if (exe)
      begin
         rf_reg <= rf_next;
         pc_reg <= pc_next;
         cy_reg <= cy_next;
         grp_reg <= grp_next;
         skip_pend_reg <= skip;
         skip_len_reg <= (cmd_nxt == NCE_NXT_ABS3) ? NCE_LEN_ABS3
            : NCE_LEN_ONE;
         op_err_reg <= op_err;
         last_mc_reg <= mc_tot;
      end
      else if (wr_ok & hit_regs)
         rf_reg <= pwdata;
      else if (wr_ok & hit_pcw)
      begin
         pc_reg <= pwdata[11:0];
         cy_reg <= pwdata[NCE_PCW_CY_BIT];
      end
   end

   // (RULE1) busy spans mc_tot periods of the divided cpu clock
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_reg <= NCE_ST_IDLE;
         mc_left_reg <= 3'd0;
         div_cnt_reg <= 4'd0;
      end
      else if (ce)
      begin
         case (state_reg)
            NCE_ST_IDLE:
               if (exe)
               begin
                  state_reg <= NCE_ST_RUN;
                  mc_left_reg <= mc_tot;
                  div_cnt_reg <= div_ld;
               end
            NCE_ST_RUN:
               if (!tick)
                  div_cnt_reg <= div_cnt_reg - 4'd1;
               else if (mc_left_reg == 3'd1)
                  state_reg <= NCE_ST_IDLE;
               else
               begin
                  mc_left_reg <= mc_left_reg - 3'd1;
                  div_cnt_reg <= div_ld;
               end
            default:
               state_reg <= NCE_ST_IDLE;
         endcase
      end
   end

   assign busy = state_reg[1];
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

   // checks; run length helper counts enabled clocks while busy
   int run_cnt;
   always_ff @(posedge clk)
   begin
      if (!rst_b || !busy)
         run_cnt <= 0;
      else if (ce)
         run_cnt <= run_cnt + 1;
   end
   wire run_end = ce & busy & tick & (mc_left_reg == 3'd1);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_exe(logic [4:0] o);
      exe && cmd_op == o;
   endsequence

   sequence s_skipped;
      go && skip_pend_reg;
   endsequence

   chk_cycle_len: assert property ( // (RULE1)
      run_end |-> run_cnt + 1 == last_mc_reg * (32'(div_ld) + 1))
      else $error("machine cycle length wrong");
   chk_skip_tie: assert property ( // (RULE2)
      exe && skip && cmd_nxt == NCE_NXT_TIE
      |=> last_mc_reg == $past(base) + 3'd1)
      else $error("table-indirect skip cost wrong");
   chk_skip_abs: assert property ( // (RULE3)
      exe && skip && cmd_nxt == NCE_NXT_ABS3
      |=> last_mc_reg == $past(base) + 3'd2)
      else $error("three-byte skip cost wrong");
   chk_hl_inc: assert property ( // (RULE4)
      s_exe(NCE_OP_LD_HLINC) |=> l == $past(l) + 4'h1
      && a == $past(mrd) && skip_pend_reg == (l == 4'h0))
      else $error("hl increment load wrong");
   chk_xch_dec: assert property ( // (RULE5)
      s_exe(NCE_OP_XCH_HLDEC)
      |=> skip_pend_reg == ($past(l) == 4'h0) && a == $past(mrd))
      else $error("exchange decrement wrong");
   chk_add_carry: assert property ( // (RULE10)
      s_exe(NCE_OP_ADD_WITH_CARRY) |=> {cy_reg, a} == $past(sum5) && !skip_pend_reg)
      else $error("add with carry wrong");
   chk_br_pcde: assert property ( // (RULE15)
      s_exe(NCE_OP_BR_PCDE)
      |=> pc_reg == {$past(pc_reg[11:8]), $past(d), $past(e)})
      else $error("pc plus de branch wrong");
   chk_rel_reach: assert property ( // (RULE16)
      s_exe(NCE_OP_BR_REL) && !rel_ok
      |=> pc_reg == $past(pc_reg) && op_err_reg)
      else $error("relative branch out of reach taken");
   chk_string_load: assert property ( // (RULE22)
      s_exe(NCE_OP_LD_AIMM) && grp_reg == NCE_GRP_A |=> a == $past(a))
      else $error("repeated string load took effect");
   chk_skip_quiet: assert property ( // (RULE23)
      s_skipped |=> rf_reg == $past(rf_reg) && cy_reg == $past(cy_reg)
      && !skip_pend_reg && !busy)
      else $error("skipped command changed state");
endmodule : nce_exec_core

// *** rtl/nce_pkg.sv ***
package nce_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] NCE_OFS_CTRL = 8'h00;
   localparam logic [7:0] NCE_OFS_CMD = 8'h04;
   localparam logic [7:0] NCE_OFS_REGS = 8'h08;
   localparam logic [7:0] NCE_OFS_STAT = 8'h0c;
   localparam logic [7:0] NCE_OFS_PCW = 8'h10;
   localparam logic [7:0] NCE_OFS_DMEM = 8'h14;
   localparam logic [7:0] NCE_OFS_PMEM = 8'h18;
   // control word fields and reset value
   localparam int NCE_CTRL_CLK_LSB = 0;
   localparam int NCE_CTRL_BE_BIT = 2;
   localparam int NCE_CTRL_BS_LSB = 4;
   localparam logic [31:0] NCE_CTRL_RST = 32'h0000_0000;
   // command word fields
   localparam int NCE_CMD_OP_LSB = 0;
   localparam int NCE_CMD_NXT_LSB = 5;
   localparam int NCE_CMD_OPND_LSB = 8;
   // nibble positions inside the register file word
   localparam int NCE_A_LSB = 0;
   localparam int NCE_X_LSB = 4;
   localparam int NCE_L_LSB = 8;
   localparam int NCE_H_LSB = 12;
   localparam int NCE_E_LSB = 16;
   localparam int NCE_D_LSB = 20;
   localparam int NCE_C_LSB = 24;
   localparam int NCE_B_LSB = 28;
   // status word fields
   localparam int NCE_ST_BUSY_BIT = 0;
   localparam int NCE_ST_CY_BIT = 1;
   localparam int NCE_ST_SKIP_BIT = 2;
   localparam int NCE_ST_ERR_BIT = 3;
   localparam int NCE_ST_MC_LSB = 4;
   localparam int NCE_ST_PC_LSB = 16;
   // pc/carry write word and memory port word
   localparam int NCE_PCW_CY_BIT = 16;
   localparam int NCE_MEM_DATA_LSB = 16;
   localparam int NCE_MEM_WR_BIT = 31;
   // data memory pages
   localparam logic [3:0] NCE_BANK0 = 4'h0;
   localparam logic [3:0] NCE_BANK15 = 4'hf;
   localparam logic [3:0] NCE_FMEM_LO_PAGE = 4'hb;
   localparam logic [3:0] NCE_FMEM_HI_PAGE = 4'hf;
   localparam logic [3:0] NCE_PMEM_TAG = 4'h4;
   localparam logic [1:0] NCE_PMEM_PAGE = 2'b11;
   // one-byte relative branch reach
   localparam logic signed [7:0] NCE_REL_BK_MIN = -8'sd15;
   localparam logic signed [7:0] NCE_REL_BK_MAX = -8'sd1;
   localparam logic signed [7:0] NCE_REL_FW_MIN = 8'sd2;
   localparam logic signed [7:0] NCE_REL_FW_MAX = 8'sd16;
   // skip costs in machine cycles and skip lengths in pc steps
   localparam logic [2:0] NCE_SKIP_LONG = 3'd2;
   localparam logic [2:0] NCE_SKIP_SHORT = 3'd1;
   localparam logic [11:0] NCE_LEN_ABS3 = 12'd3;
   localparam logic [11:0] NCE_LEN_ONE = 12'd1;

   typedef enum logic [4:0] {
      NCE_OP_NOP = 5'h00,
      NCE_OP_LD_HLINC = 5'h01,
      NCE_OP_XCH_HLDEC = 5'h02,
      NCE_OP_TBL_PCDE = 5'h03,
      NCE_OP_BIT_LD = 5'h04,
      NCE_OP_BIT_ST = 5'h05,
      NCE_OP_ADD_WITH_CARRY = 5'h06,
      NCE_OP_SUB_WITH_BORROW = 5'h07,
      NCE_OP_ROTATE_RIGHT_CARRY = 5'h08,
      NCE_OP_CY_AND = 5'h09,
      NCE_OP_CY_OR = 5'h0a,
      NCE_OP_CY_XOR = 5'h0b,
      NCE_OP_TSC = 5'h0c,
      NCE_OP_BR_PCDE = 5'h0d,
      NCE_OP_BR_REL = 5'h0e,
      NCE_OP_LD_AIMM = 5'h0f,
      NCE_OP_LD_HLIMM = 5'h10,
      NCE_OP_LD_AMEM = 5'h11,
      NCE_OP_LD_ADE = 5'h12
   } nce_op_e;

   typedef enum logic [1:0] {
      NCE_NXT_PLAIN = 2'd0,
      NCE_NXT_ABS3 = 2'd1,
      NCE_NXT_TIE = 2'd2
   } nce_nxt_e;

   typedef enum logic [1:0] {
      NCE_GRP_NONE = 2'd0,
      NCE_GRP_A = 2'd1,
      NCE_GRP_HL = 2'd2
   } nce_grp_e;

   typedef enum logic [1:0] {
      NCE_ST_IDLE = 2'b01,
      NCE_ST_RUN = 2'b10
   } nce_state_e;

   // cpu clock divide-minus-one per clock control setting
   function automatic logic [3:0] nce_div(input logic [1:0] sel);
      case (sel)
         2'd0: nce_div = 4'd7;
         2'd1: nce_div = 4'd3;
         2'd2: nce_div = 4'd1;
         default: nce_div = 4'd0;
      endcase
   endfunction : nce_div

   function automatic logic [2:0] nce_base(input logic [4:0] op);
      case (op)
         NCE_OP_TBL_PCDE, NCE_OP_BR_PCDE: nce_base = 3'd3;
         NCE_OP_ADD_WITH_CARRY, NCE_OP_SUB_WITH_BORROW, NCE_OP_ROTATE_RIGHT_CARRY, NCE_OP_NOP,
         NCE_OP_LD_AIMM, NCE_OP_LD_ADE: nce_base = 3'd1;
         default: nce_base = 3'd2;
      endcase
   endfunction : nce_base
endpackage : nce_pkg

// *** verification/nce_exec_core_tb.sv ***
module nce_exec_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nce_pkg::*;
   logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, busy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, s;
   logic e, cy, ec;
   logic [3:0] a, m;
   logic [4:0] t;
   logic [7:0] b;
   int miscompares, tests_run, k, hi;
   int offs[8] = '{-15, -1, 2, 16, 0, 1, 17, -16};
   nce_op_e op;

   nce_exec_core nce_exec_core_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finish_test;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   task automatic cmp_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : cmp_word

   task automatic cmp_flag(input string what, input logic exp,
                           input logic got);
      tests_run++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %b seen %b", what, exp, got);
         miscompares++;
      end
   endtask : cmp_flag

   // request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, r, e);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
      apb(1'b0, ad, 32'h0, d, e);
   endtask : rd_reg

   task automatic run(input nce_op_e o, input nce_nxt_e nx,
                      input logic [7:0] opnd);
      int n;
      wr_reg(NCE_OFS_CMD, {16'h0, opnd, 1'b0, nx, o});
      repeat (2) @(posedge clk);
      for (n = 0; n < 200; n++)
      begin
         if (busy === 1'b0)
            break;
         @(posedge clk);
      end
      if (n == 200)
      begin
         miscompares++;
         finish_test();
      end
   endtask : run

   task automatic mem_wr(input logic [11:0] ad, input logic [3:0] d);
      wr_reg(NCE_OFS_DMEM, {1'b1, 11'h0, d, 4'h0, ad});
   endtask : mem_wr

   task automatic mem_chk(input logic [11:0] ad, input logic [3:0] d);
      wr_reg(NCE_OFS_DMEM, {20'h0, ad});
      rd_reg(NCE_OFS_DMEM, r);
      cmp_word("dmem", {12'h0, d, 4'h0, ad}, r);
   endtask : mem_chk

   task automatic stat_chk(input logic [2:0] cyc, input logic sk);
      rd_reg(NCE_OFS_STAT, s);
      cmp_word("cycles", {29'h0, cyc}, {29'h0, s[6:4]});
      cmp_flag("skip", sk, s[2]);
   endtask : stat_chk

   task automatic acc_chk(input logic [31:0] exp);
      rd_reg(NCE_OFS_REGS, r);
      cmp_word("regs", exp, r);
   endtask : acc_chk

   initial
   begin
      ce = 1'b1;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      k = $urandom(76676);
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(NCE_OFS_CTRL, r);
      cmp_word("ctrl", NCE_CTRL_RST, r);
      stat_chk(3'd0, 1'b0);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      cmp_flag("pslverr", 1'b1, e);
      cmp_word("unmapped", 32'h0, r);
      for (k = 0; k < 4; k++)
      begin
         wr_reg(NCE_OFS_CTRL, 32'(k));
         wr_reg(NCE_OFS_CMD, 32'h0);
         hi = 0;
         repeat (24)
         begin
            @(posedge clk);
            if (busy === 1'b1)
               hi++;
         end
         cmp_word("busy clocks", 32'(8 >> k), 32'(hi));
      end
      wr_reg(NCE_OFS_CTRL, 32'h0);
      wr_reg(NCE_OFS_CMD, 32'h0);
      apb(1'b1, NCE_OFS_CMD, 32'h060f, r, e);
      cmp_flag("cmd while busy", 1'b1, e);
      wr_reg(NCE_OFS_CTRL, 32'h3);
      repeat (10) @(posedge clk);
      // load with increment, wrap skips a plain one
      a = $urandom;
      m = $urandom;
      wr_reg(NCE_OFS_REGS, {16'h0, 8'h2f, 4'h0, a});
      mem_wr(12'h02f, m);
      run(NCE_OP_LD_HLINC, NCE_NXT_PLAIN, 8'h00);
      acc_chk({16'h0, 8'h20, 4'h0, m});
      stat_chk(3'd3, 1'b1);
      wr_reg(NCE_OFS_CMD, {16'h0, 8'h05, 3'h0, NCE_OP_LD_AIMM});
      acc_chk({16'h0, 8'h20, 4'h0, m});
      rd_reg(NCE_OFS_STAT, s);
      cmp_word("pc", 32'h1, {20'h0, s[27:16]});
      mem_wr(12'h020, a);
      wr_reg(NCE_OFS_REGS, {16'h0, 8'h20, 4'h0, m});
      run(NCE_OP_XCH_HLDEC, NCE_NXT_ABS3, 8'h00);
      acc_chk({16'h0, 8'h2f, 4'h0, a});
      mem_chk(12'h020, m);
      stat_chk(3'd4, 1'b1);
      wr_reg(NCE_OFS_CMD, 32'h0);
      rd_reg(NCE_OFS_STAT, s);
      cmp_word("pc", 32'h4, {20'h0, s[27:16]});
      // set bit skips table-indirect execute in one cycle
      mem_wr(12'hff3, 4'h2);
      run(NCE_OP_TSC, NCE_NXT_TIE, 8'hd3);
      stat_chk(3'd3, 1'b1);
      mem_chk(12'hff3, 4'h0);
      wr_reg(NCE_OFS_CMD, 32'h0);
      run(NCE_OP_TSC, NCE_NXT_PLAIN, 8'hd3);
      stat_chk(3'd2, 1'b0);
      for (k = 0; k < 9; k++)
      begin
         a = $urandom;
         m = $urandom;
         cy = $urandom;
         op = (k % 3 == 0) ? NCE_OP_ADD_WITH_CARRY :
              (k % 3 == 1) ? NCE_OP_SUB_WITH_BORROW : NCE_OP_ROTATE_RIGHT_CARRY;
         wr_reg(NCE_OFS_REGS, {16'h0, 8'h01, 4'h0, a});
         mem_wr(12'h001, m);
         wr_reg(NCE_OFS_PCW, {15'h0, cy, 16'h0});
         run(op, NCE_NXT_PLAIN, 8'h00);
         t = (op == NCE_OP_ADD_WITH_CARRY) ? {1'b0, a} + {1'b0, m} + 5'(cy) :
             (op == NCE_OP_SUB_WITH_BORROW) ? {1'b0, a} - {1'b0, m} - 5'(cy) :
             {a[0], cy, a[3:1]};
         acc_chk({16'h0, 8'h01, 4'h0, t[3:0]});
         stat_chk(3'd1, 1'b0);
         cmp_flag("carry", t[4], s[1]);
      end
      // fixed bits stay in bank 15 with bank 4 selected
      wr_reg(NCE_OFS_CTRL, 32'h47);
      for (k = 0; k < 6; k++)
      begin
         m = $urandom;
         cy = $urandom;
         op = nce_op_e'(5'(NCE_OP_CY_AND + k % 3));
         mem_wr(12'hfb0 | 12'(k), m);
         wr_reg(NCE_OFS_PCW, {15'h0, cy, 16'h0});
         run(op, NCE_NXT_PLAIN, 8'ha0 | 8'(k));
         ec = (k % 3 == 0) ? cy & m[2] : (k % 3 == 1) ? cy | m[2] :
              cy ^ m[2];
         stat_chk(3'd2, 1'b0);
         cmp_flag("carry", ec, s[1]);
      end
      // peripheral bit from operand and L
      wr_reg(NCE_OFS_REGS, {16'h0, 8'h0e, 8'h00});
      mem_wr(12'hfd7, 4'h0);
      wr_reg(NCE_OFS_PCW, 32'h0001_0000);
      run(NCE_OP_BIT_ST, NCE_NXT_PLAIN, 8'h45);
      mem_chk(12'hfd7, 4'h4);
      // H-relative bit in the selected bank
      wr_reg(NCE_OFS_REGS, {16'h0, 8'h40, 8'h00});
      mem_wr(12'h449, 4'h8);
      run(NCE_OP_BIT_LD, NCE_NXT_PLAIN, 8'h39);
      stat_chk(3'd2, 1'b0);
      cmp_flag("carry", 1'b1, s[1]);
      run(NCE_OP_BIT_LD, NCE_NXT_PLAIN, 8'h65);
      rd_reg(NCE_OFS_STAT, s);
      cmp_flag("error", 1'b1, s[3]);
      m = $urandom;
      mem_wr(12'h485, m);
      run(NCE_OP_LD_AMEM, NCE_NXT_PLAIN, 8'h85);
      acc_chk({16'h0, 8'h40, 4'h0, m});
      wr_reg(NCE_OFS_REGS, {8'h0, 8'h37, 16'h0});
      mem_wr(12'h037, ~m);
      run(NCE_OP_LD_ADE, NCE_NXT_PLAIN, 8'h00);
      acc_chk({8'h0, 8'h37, 12'h0, ~m});
      wr_reg(NCE_OFS_CTRL, 32'h3);
      mem_wr(12'hf85, m ^ 4'h5);
      run(NCE_OP_LD_AMEM, NCE_NXT_PLAIN, 8'h85);
      acc_chk({8'h0, 8'h37, 12'h0, m ^ 4'h5});
      // table read and branch within the pc page
      b = $urandom;
      wr_reg(NCE_OFS_REGS, {8'h0, b, 16'h0});
      wr_reg(NCE_OFS_PCW, 32'h0000_05a0);
      wr_reg(NCE_OFS_PMEM, {8'h80, ~b, 4'h0, 4'h5, b});
      run(NCE_OP_TBL_PCDE, NCE_NXT_PLAIN, 8'h00);
      acc_chk({8'h0, b, 8'h0, ~b});
      stat_chk(3'd3, 1'b0);
      run(NCE_OP_BR_PCDE, NCE_NXT_PLAIN, 8'h00);
      stat_chk(3'd3, 1'b0);
      cmp_word("pc", {20'h0, 4'h5, b}, {20'h0, s[27:16]});
      // relative reach edges, inside and outside
      for (k = 0; k < 8; k++)
      begin
         wr_reg(NCE_OFS_PCW, 32'h0000_0200);
         run(NCE_OP_BR_REL, NCE_NXT_PLAIN, 8'(offs[k]));
         rd_reg(NCE_OFS_STAT, s);
         cmp_word("pc", (k < 4) ? 32'h200 + 32'(offs[k]) : 32'h200,
                  {20'h0, s[27:16]});
         if (k >= 4)
            cmp_flag("error", 1'b1, s[3]);
      end
      // only the first load of a group acts
      run(NCE_OP_LD_AIMM, NCE_NXT_PLAIN, 8'h05);
      run(NCE_OP_LD_AIMM, NCE_NXT_PLAIN, 8'h09);
      run(NCE_OP_LD_HLIMM, NCE_NXT_PLAIN, 8'h3c);
      run(NCE_OP_LD_HLIMM, NCE_NXT_PLAIN, 8'h11);
      acc_chk({8'h0, b, 8'h3c, ~b[7:4], 4'h5});
      finish_test();
   end
endmodule : nce_exec_core_tb
